// File: verilog/dcyh_pkg.sv
// Package for the DMA word handshake: widths, states and cycle figures.
// Assumes a single 40 MHz clock shared by every module of the block.
package dcyh_pkg;

    localparam int unsigned DCYH_DATA_W = 16;
    localparam int unsigned DCYH_COUNT_W = 16;
    localparam int unsigned DCYH_CLK_PERIOD_NS = 25;
    // Setup of outbound data before the strobe's leading edge
    localparam int unsigned DCYH_SETUP_NS = 25;
    localparam int unsigned DCYH_SETUP_CYC =
        (DCYH_SETUP_NS + DCYH_CLK_PERIOD_NS - 1) / DCYH_CLK_PERIOD_NS;
    localparam logic [DCYH_COUNT_W-1:0] DCYH_COUNT_RST = 16'h0000;
    localparam logic [DCYH_DATA_W-1:0] DCYH_DATA_RST = 16'h0000;

    typedef enum logic [4:0] {
        DCYH_IDLE  = 5'h01,
        DCYH_SETUP = 5'h02,
        DCYH_STRB  = 5'h04,
        DCYH_WAIT  = 5'h08,
        DCYH_DONE  = 5'h10
    } dcyh_state_t;

endpackage

// File: verilog/dcyh_sync_if.sv
// Interface carrying synchronised link levels from the pin stage to the engine.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ps
interface dcyh_sync_if #(parameter int unsigned W = 16);
    logic ready;
    logic busy;
    logic [W-1:0] data;
    modport src (output ready, busy, data);
    modport dst (input ready, busy, data);
endinterface

// File: verilog/dcyh_pin_sync.sv
// Two-flop synchronisers for the host's ready, busy and inbound data pins.
// Assumes the host drives these pins without reference to core_clk.
`timescale 1ns/1ps
module dcyh_pin_sync #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Raw pins
    input wire logic host_ready,
    input wire logic host_busy,
    input wire logic [W-1:0] host_data_in,
    // Synchronised levels
    dcyh_sync_if.src sync
);
    logic [W+1:0] meta_q;
    logic [W+1:0] meta_d;
    logic [W+1:0] stab_q;
    logic [W+1:0] stab_d;

    always_comb begin
        meta_d = {host_ready, host_busy, host_data_in};
        stab_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q <= '0;
            stab_q <= '0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync.ready = stab_q[W+1];
    assign sync.busy = stab_q[W];
    assign sync.data = stab_q[W-1:0];
endmodule // dcyh_pin_sync

// File: verilog/dcyh_engine.sv
// DMA word handshake engine: the board strobes, the host answers with busy.
// Assumes the host pins are asynchronous; firmware loads the transfer after ready.
`timescale 1ns/1ps

// Notes on behaviour
// - Only this engine ever starts a transfer
// - Transfer load accepted only while ready seen
// - Loaded transfer strobes each word automatically
// - Outbound word valid before strobe leading edge
// - Inbound word latched at busy trailing edge
// - Strobing stops when word count exhausted
module dcyh_engine
    import dcyh_pkg::*;
#(
    parameter int unsigned DATA_W = dcyh_pkg::DCYH_DATA_W,
    parameter int unsigned COUNT_W = dcyh_pkg::DCYH_COUNT_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Firmware side
    input wire logic load,
    input wire logic to_host,
    input wire logic [COUNT_W-1:0] word_total,
    output logic host_seen,
    output logic load_refused,
    output logic active,
    output logic done,
    // Word source and sink
    input wire logic [DATA_W-1:0] out_word,
    output logic out_take,
    output logic [DATA_W-1:0] in_word,
    output logic in_valid,
    output logic [COUNT_W-1:0] words_done,
    // Link pins
    input wire logic host_ready,
    input wire logic host_busy,
    input wire logic [DATA_W-1:0] host_data_in,
    output logic cycle_req,
    output logic [DATA_W-1:0] host_data_out
);
    import dcyh_pkg::*;

    dcyh_sync_if #(.W(DATA_W)) sync_bus ();

    dcyh_pin_sync #(.W(DATA_W)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .host_ready(host_ready),
        .host_busy(host_busy),
        .host_data_in(host_data_in),
        .sync(sync_bus)
    );

    dcyh_state_t state_q;
    dcyh_state_t state_d;
    logic dir_q;
    logic dir_d;
    logic [COUNT_W-1:0] total_q;
    logic [COUNT_W-1:0] total_d;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic [DATA_W-1:0] din_q;
    logic [DATA_W-1:0] din_d;
    logic busy_prev_q;
    logic busy_prev_d;
    logic req_q;
    logic req_d;
    logic take_q;
    logic take_d;
    logic inv_q;
    logic inv_d;
    logic done_q;
    logic done_d;
    logic refused_q;
    logic refused_d;
    logic seen_q;
    logic seen_d;
    logic busy_fall;

    // Busy trailing edge, seen after the synchroniser
    assign busy_fall = busy_prev_q && !sync_bus.busy;

    // Next state and data path
    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        total_d = total_q;
        count_d = count_q;
        dout_d = dout_q;
        din_d = din_q;
        req_d = req_q;
        take_d = 1'b0;
        inv_d = 1'b0;
        done_d = done_q;
        refused_d = 1'b0;
        seen_d = sync_bus.ready;
        busy_prev_d = sync_bus.busy;
        unique case (state_q)
            DCYH_IDLE: begin
                if (load) begin
                    if (sync_bus.ready && word_total != DCYH_COUNT_RST) begin
                        dir_d = to_host;
                        total_d = word_total;
                        count_d = DCYH_COUNT_RST;
                        done_d = 1'b0;
                        state_d = DCYH_SETUP;
                        if (to_host) begin
                            dout_d = out_word;
                            take_d = 1'b1;
                        end
                    end else begin
                        refused_d = 1'b1;
                    end
                end
            end
            DCYH_SETUP: begin
                // Data stood on the pins one full cycle before the strobe
                req_d = 1'b1;
                state_d = DCYH_STRB;
            end
            DCYH_STRB: begin
                if (sync_bus.busy) begin
                    req_d = 1'b0;
                    state_d = DCYH_WAIT;
                end
            end
            DCYH_WAIT: begin
                if (busy_fall) begin
                    if (!dir_q) begin
                        din_d = sync_bus.data;
                        inv_d = 1'b1;
                    end
                    count_d = COUNT_W'(count_q + 1'b1);
                    if (COUNT_W'(count_q + 1'b1) == total_q) begin
                        state_d = DCYH_DONE;
                    end else begin
                        state_d = DCYH_SETUP;
                        if (dir_q) begin
                            dout_d = out_word;
                            take_d = 1'b1;
                        end
                    end
                end
            end
            DCYH_DONE: begin
                done_d = 1'b1;
                state_d = DCYH_IDLE;
            end
            default: state_d = DCYH_IDLE;
        endcase
        // Loads outside idle are refused, never queued
        if (load && (state_q != DCYH_IDLE)) begin
            refused_d = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= DCYH_IDLE;
            dir_q <= 1'b0;
            total_q <= DCYH_COUNT_RST;
            count_q <= DCYH_COUNT_RST;
            dout_q <= DCYH_DATA_RST;
            din_q <= DCYH_DATA_RST;
            busy_prev_q <= 1'b0;
            req_q <= 1'b0;
            take_q <= 1'b0;
            inv_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dir_q <= dir_d;
            total_q <= total_d;
            count_q <= count_d;
            dout_q <= dout_d;
            din_q <= din_d;
            busy_prev_q <= busy_prev_d;
            req_q <= req_d;
            take_q <= take_d;
            inv_q <= inv_d;
            done_q <= done_d;
            refused_q <= refused_d;
            seen_q <= seen_d;
        end
    end

    // Active covers the done cycle so a load there is refused
    logic active_q;
    logic active_d;
    always_comb begin
        active_d = (state_d != DCYH_IDLE);
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end

    // Outputs straight from flip-flops
    assign cycle_req = req_q;
    assign host_data_out = dout_q;
    assign in_word = din_q;
    assign in_valid = inv_q;
    assign out_take = take_q;
    assign words_done = count_q;
    assign done = done_q;
    assign active = active_q;
    assign load_refused = refused_q;
    assign host_seen = seen_q;
endmodule // dcyh_engine

// File: dv/dcyh_engine_sva.sv
// Port checker for the DMA word handshake engine.
// Assumes a bind onto dcyh_engine, one clock, synchronous reset.
`timescale 1ns/1ps
module dcyh_engine_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched ports
    input wire logic load,
    input wire logic [15:0] word_total,
    input wire logic host_seen,
    input wire logic load_refused,
    input wire logic active,
    input wire logic done,
    input wire logic host_busy,
    input wire logic cycle_req,
    input wire logic [15:0] host_data_out,
    input wire logic [15:0] words_done
);
    logic [15:0] total_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk) begin
        if (load && !active && host_seen) begin
            total_q <= word_total;
        end
    end
    a_req_in_xfer: assert property (cycle_req |-> active)
        else $error("strobe outside a transfer");
    a_zero_refused: assert property (load && word_total == 16'h0000 && !active
        |=> load_refused && !active)
        else $error("empty load not refused");
    a_load_strobes: assert property (load && !active && host_seen && word_total != 16'h0000
        |-> ##2 cycle_req)
        else $error("no strobe after load");
    a_data_setup: assert property ($rose(cycle_req) |-> $stable(host_data_out))
        else $error("data moved at strobe edge");
    a_req_holds: assert property (cycle_req && !host_busy |=> cycle_req)
        else $error("strobe dropped before busy");
    a_req_drops: assert property (cycle_req && host_busy |-> ##[1:4] !cycle_req)
        else $error("strobe not ended by busy");
    a_count_step: assert property ($changed(words_done) && words_done != 16'h0000
        |-> words_done == $past(words_done) + 16'h0001)
        else $error("count skipped");
    a_stop_at_total: assert property (cycle_req |-> words_done < total_q)
        else $error("strobe past word count");
    a_done_count: assert property ($rose(done) |-> !active && words_done == total_q)
        else $error("done at wrong count");
endmodule // dcyh_engine_sva
bind dcyh_engine dcyh_engine_sva dcyh_engine_sva_inst (
    .core_clk(core_clk),
    .reset(reset),
    .load(load),
    .word_total(word_total),
    .host_seen(host_seen),
    .load_refused(load_refused),
    .active(active),
    .done(done),
    .host_busy(host_busy),
    .cycle_req(cycle_req),
    .host_data_out(host_data_out),
    .words_done(words_done)
);

// File: dv/dcyh_host_model.sv
// Host responder model: answers each strobe with busy.
// Assumes strobes come from the engine on core_clk.
`timescale 1ns/1ps
module dcyh_host_model (
    // Controls
    input wire logic core_clk,
    input wire logic armed,
    input wire logic [3:0] lag,
    // Link pins
    input wire logic cycle_req,
    input wire logic [15:0] host_data_out,
    output logic host_ready,
    output logic host_busy,
    output logic [15:0] host_data_in
);
    logic [15:0] got [0:15];
    int n = 0;
    assign host_ready = armed;
    initial begin
        host_busy = 1'b0;
        host_data_in = 16'h5a5a;
        forever begin
            @(posedge core_clk);
            if (cycle_req === 1'b1) begin
                got[n] = host_data_out;
                repeat (lag) @(posedge core_clk);
                host_busy <= 1'b1;
                host_data_in <= 16'ha500 + 16'(n);
                while (cycle_req !== 1'b0) @(posedge core_clk);
                host_busy <= 1'b0;
                repeat (4) @(posedge core_clk);
                host_data_in <= ~host_data_in;
                n = n + 1;
            end
        end
    end
endmodule // dcyh_host_model

// File: dv/test_dcyh_engine.sv
// Bench for the DMA word handshake engine.
// Assumes the host model stands on the link pins.
`timescale 1ns/1ps
module test_dcyh_engine;
    logic core_clk = 1'b0, reset = 1'b1, load = 1'b0, to_host = 1'b0, armed = 1'b0, ref_seen;
    logic [15:0] word_total = 16'h0000, out_word = 16'hc000, in_word, words_done;
    logic [15:0] host_data_in, host_data_out, ins [0:15];
    logic host_seen, load_refused, active, done, out_take, in_valid;
    logic host_ready, host_busy, cycle_req;
    logic [3:0] lag = 4'h0;
    int n_mismatch = 0, check_count = 0, ni = 0, cyc = 0;
    dcyh_engine dcyh_engine_inst (.core_clk, .reset, .load, .to_host, .word_total, .host_seen,
        .load_refused, .active, .done, .out_word, .out_take, .in_word, .in_valid, .words_done,
        .host_ready, .host_busy, .host_data_in, .cycle_req, .host_data_out);
    dcyh_host_model dcyh_host_model_inst (.core_clk, .armed, .lag, .cycle_req, .host_data_out,
        .host_ready, .host_busy, .host_data_in);
    always #12.5 core_clk = ~core_clk;
    always @(negedge core_clk) if (out_take === 1'b1) out_word <= out_word + 16'h0001;
    always @(posedge core_clk) begin
        cyc++;
        if (load_refused === 1'b1) ref_seen = 1'b1;
        if (in_valid === 1'b1) begin
            ins[ni] = in_word;
            ni++;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic dir, input logic [15:0] total);
        @(negedge core_clk);
        load = 1'b1;
        to_host = dir;
        word_total = total;
        @(negedge core_clk);
        load = 1'b0;
    endtask
    task automatic wait_done;
        int i;
        @(negedge core_clk);
        for (i = 0; i < 600 && done !== 1'b1; i++) @(negedge core_clk);
        repeat (10) @(negedge core_clk);
    endtask
    task automatic t_refuse;
        ref_seen = 1'b0;
        go(1'b1, 16'h0003);
        repeat (2) @(negedge core_clk);
        chk({14'h0, ref_seen, active}, 16'h0002);
        armed = 1'b1;
        repeat (5) @(negedge core_clk);
        chk({15'h0, host_seen}, 16'h0001);
        ref_seen = 1'b0;
        go(1'b1, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk({14'h0, ref_seen, active}, 16'h0002);
    endtask
    task automatic t_out;
        logic [15:0] base;
        int m0;
        base = out_word;
        m0 = dcyh_host_model_inst.n;
        go(1'b1, 16'h0003);
        wait_done();
        for (int k = 0; k < 3; k++) chk(dcyh_host_model_inst.got[m0 + k], base + 16'(k));
        chk(16'(dcyh_host_model_inst.n - m0), 16'h0003);
        chk({words_done[14:0], done}, 16'h0007);
    endtask
    task automatic t_in;
        int i0;
        int m0;
        i0 = ni;
        m0 = dcyh_host_model_inst.n;
        lag = 4'h3;
        go(1'b0, 16'h0002);
        ref_seen = 1'b0;
        go(1'b0, 16'h0005);
        @(negedge core_clk);
        chk({15'h0, ref_seen}, 16'h0001);
        wait_done();
        chk(16'(ni - i0), 16'h0002);
        for (int k = 0; k < 2; k++) chk(ins[i0 + k], 16'ha500 + 16'(m0 + k));
        chk(words_done, 16'h0002);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        t_refuse();
        t_out();
        t_in();
        give_verdict();
    end
endmodule // test_dcyh_engine
